/* logic/wdrc_pkg.sv */
// Package with constants for the watchdog and reset control block
package wdrc_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] ADDR_PERIOD_SEL   = 4'h0;     // Period select register
   localparam logic [3:0] ADDR_CTRL_ONE     = 4'h1;     // Control register one (enable code)
   localparam logic [3:0] ADDR_STATUS       = 4'h2;     // Status flags
   localparam logic [3:0] ADDR_CONFIG       = 4'h3;     // Configuration options
   localparam logic [3:0] ADDR_CLEAR        = 4'h4;     // Clear / power-down command register
   // Reset values
   localparam logic [2:0] PERIOD_SEL_RST    = 3'h7;     // Longest time-out after power-up
   localparam logic [3:0] EN_CODE_OFF       = 4'hA;     // 1010B disables the watchdog
   localparam logic [3:0] EN_CODE_RECOMMEND = 4'h5;     // 0101B suggested enabling code
   localparam logic [7:0] PORT_RST          = 8'hFF;    // Ports come up as inputs
   localparam logic [7:0] CONFIG_RST        = 8'h00;    // Configuration default
   // Configuration field positions
   localparam int CFG_WDT_EN   = 0;                     // Watchdog forced on
   localparam int CFG_DUAL_CLR = 1;                     // Two-instruction clear
   localparam int CFG_SRC_LO   = 2;                     // Clock source, two bits
   localparam int CFG_SST_SHORT= 4;                     // Short start-up for RC source
   localparam int CFG_CRYSTAL  = 5;                     // System clock is a crystal
   // Clear command codes written to the clear register
   localparam logic [1:0] CMD_SINGLE = 2'h1;            // Single clear instruction
   localparam logic [1:0] CMD_HALF1  = 2'h2;            // First half clear
   localparam logic [1:0] CMD_HALF2  = 2'h3;            // Second half clear
   localparam int CMD_HALT_BIT = 2;                     // Power-down instruction bit
   // Watchdog clock sources
   typedef enum logic [1:0] {
      WDRC_SRC_LXT  = 2'h0,                             // Low-frequency crystal
      WDRC_SRC_SYS4 = 2'h1,                             // System clock over 4
      WDRC_SRC_LOW_SPEED_INTERNAL_OSC = 2'h2                              // Low-speed internal RC
   } wdrc_src_t;
   // Timing
   localparam int SYS_CLK_HZ       = 50000000;          // Clock rate
   localparam int STARTUP_DELAY_MS = 100;               // Start-up delay after reset line rises
   localparam int STARTUP_CYCLES   = SYS_CLK_HZ / 1000 * STARTUP_DELAY_MS;
   localparam logic [10:0] SST_LONG  = 11'h400;         // 1024 clocks
   localparam logic [10:0] SST_SHORT = 11'h002;         // 2 clocks
   localparam logic [1:0]  SYS_DIV   = 2'h3;            // Divide-by-4 terminal count
   // Control states, Gray along the usual path except the wake-to-run step
   typedef enum logic [1:0] {
      WDRC_ST_DELAY = 2'b00,                            // Start-up delay after reset
      WDRC_ST_RUN   = 2'b01,                            // Normal operation
      WDRC_ST_HALT  = 2'b11,                            // Idle or sleep
      WDRC_ST_WAKE  = 2'b10                             // Start-up timer after wake
   } wdrc_state_t;
endpackage

/* logic/wdrc_top.sv */
// Watchdog timer with reset and wake-up control
`timescale 1ns/1ps
// What this block does
// - Overflow in normal operation resets the device
// - Disabled watchdog ignores clear instructions
// - Option forces on, else code decides
// - Code 1010B disables; power-up value
// - Any other code enables the watchdog
// - Option picks crystal, sysclk/4 or RC
// - Sysclk/4 source stops in idle/sleep
// - Period code selects 2^8 to 2^15
// - Period bits reset ones; upper bits zero
// - Normal time-out: full reset, expired flag
// - Halted time-out wakes, resets PC only
// - Pin, valid clear or halt clear counter
// - Option picks single or dual clear
// - Dual halves must alternate to clear
// - Power-on zeroes program counter
// - Power-on sets port registers to ones
// - Start-up delay after reset line rises
// - Pin reset restarts at address zero
// - Supply drop acts like pin reset
// - Flags per reset kind as tabled
// - Halt sets power-down, clears expired
// - Wake delay 1024 or 2 clocks
module wdrc_top #(
   parameter int STARTUP_CNT = wdrc_pkg::STARTUP_CYCLES     // Start-up delay in clocks
) (
   input  wire logic       clk_sys,                         // System clock
   input  wire logic       rst,                             // Power-on reset, sync, high
   input  wire logic       external_clear_pin_n,            // External reset pin, low active
   input  wire logic       supply_drop_restart,             // Supply-drop detector
   input  wire logic       low_freq_crystal_clock,          // Crystal tick, one-cycle pulse
   input  wire logic       low_speed_internal_osc,          // RC tick, one-cycle pulse
   input  wire logic       halt_req,                        // CPU enters idle/sleep
   input  wire logic       wake_req,                        // Other wake-up source
   input  wire logic [3:0] reg_addr,                        // Register address
   input  wire logic [7:0] reg_wdata,                       // Write data
   input  wire logic       reg_wr,                          // Write strobe
   input  wire logic       reg_rd,                          // Read strobe
   output logic      [7:0] reg_rdata,                       // Read data, one cycle later
   output logic            cpu_reset,                       // Full device reset held
   output logic            pc_clear,                        // Clear PC and stack, pulse
   output logic            cpu_run,                         // Execution allowed
   output logic      [7:0] port_data,                       // Port data register
   output logic      [7:0] port_ctrl,                       // Port control register
   output logic            watchdog_active                  // Watchdog running
);
   logic [2:0]  period_sel_r;                                // Period select bits
   logic [3:0]  enable_code_r;                               // Enable code
   logic [7:0]  config_r;                                    // Configuration options
   logic        expired_r;                                   // Watchdog-expired flag
   logic        pdown_r;                                     // Power-down flag
   logic        last_half_r;                                 // Last half clear seen (1 = second)
   logic        half_valid_r;                                // A half clear is pending
   logic [15:0] wdt_cnt_r;                                   // Watchdog counter
   logic [1:0]  div_r;                                       // Sysclk divider
   logic [31:0] delay_cnt_r;                                 // Start-up/wake counter
   logic        pin_low_r;                                   // Reset pin or supply drop held
   wdrc_pkg::wdrc_state_t state_r;                           // Control state
   logic        active;                                      // Watchdog enabled
   logic        tick;                                        // Watchdog clock enable
   logic        overflow;                                    // Counter reaches period
   logic        wr_clear;                                    // Clear register written
   logic        sw_clear;                                    // Valid software clear
   logic        halt_cmd;                                    // Power-down instruction
   logic        ext_rst;                                     // Pin or supply-drop reset
   logic        halted;                                      // In idle/sleep
   logic [15:0] limit;                                       // Time-out count minus one

   // Enable decision: option forces on, else code other than 1010B
   assign active   = config_r[wdrc_pkg::CFG_WDT_EN] ||
                     (enable_code_r != wdrc_pkg::EN_CODE_OFF);
   assign ext_rst  = !external_clear_pin_n || supply_drop_restart;
   assign halted   = (state_r == wdrc_pkg::WDRC_ST_HALT);
   assign wr_clear = reg_wr && (reg_addr == wdrc_pkg::ADDR_CLEAR);
   assign halt_cmd = (state_r == wdrc_pkg::WDRC_ST_RUN) &&
                     ((wr_clear && reg_wdata[wdrc_pkg::CMD_HALT_BIT]) || halt_req);
   // Period lengths 2^8 .. 2^15 counted from zero
   assign limit    = 16'((32'h100 << period_sel_r) - 32'h1);
   assign overflow = active && (wdt_cnt_r == limit) && tick;

   // Tick select per clock source
   always_comb begin
      case (wdrc_pkg::wdrc_src_t'(config_r[wdrc_pkg::CFG_SRC_LO +: 2]))
         wdrc_pkg::WDRC_SRC_LXT:  tick = low_freq_crystal_clock;
         wdrc_pkg::WDRC_SRC_SYS4: tick = (div_r == wdrc_pkg::SYS_DIV) && !halted;
         wdrc_pkg::WDRC_SRC_LOW_SPEED_INTERNAL_OSC: tick = low_speed_internal_osc;
         default:                 tick = 1'b0;
      endcase
   end

   // Software clear decode, single or alternating halves
   always_comb begin
      sw_clear = 1'b0;
      if (wr_clear && active && (state_r == wdrc_pkg::WDRC_ST_RUN)) begin
         if (!config_r[wdrc_pkg::CFG_DUAL_CLR]) begin
            sw_clear = (reg_wdata[1:0] == wdrc_pkg::CMD_SINGLE);
         end else if (reg_wdata[1:0] == wdrc_pkg::CMD_HALF1) begin
            sw_clear = half_valid_r && last_half_r;
         end else if (reg_wdata[1:0] == wdrc_pkg::CMD_HALF2) begin
            sw_clear = half_valid_r && !last_half_r;
         end
      end
   end

   // Half clear tracker: a repeated half leaves it unchanged
   always_ff @(posedge clk_sys) begin
      if (rst || ext_rst || halt_cmd || sw_clear) begin
         half_valid_r <= 1'b0;
         last_half_r  <= 1'b0;
      end else if (wr_clear && active && config_r[wdrc_pkg::CFG_DUAL_CLR] &&
                   (reg_wdata[1:0] == wdrc_pkg::CMD_HALF1 || reg_wdata[1:0] == wdrc_pkg::CMD_HALF2)) begin
         half_valid_r <= 1'b1;
         last_half_r  <= (reg_wdata[1:0] == wdrc_pkg::CMD_HALF2);
      end
   end

   // System clock divide by four
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   // Watchdog counter
   always_ff @(posedge clk_sys) begin
      if (rst || ext_rst || sw_clear || halt_cmd || overflow || !active) begin
         wdt_cnt_r <= 16'h0000;
      end else if (tick && (state_r == wdrc_pkg::WDRC_ST_RUN || halted)) begin
         wdt_cnt_r <= wdt_cnt_r + 16'h0001;
      end
   end

   // Register writes: period select, enable code, configuration
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         period_sel_r  <= wdrc_pkg::PERIOD_SEL_RST;
         enable_code_r <= wdrc_pkg::EN_CODE_OFF;
         config_r      <= wdrc_pkg::CONFIG_RST;
      end else if ((ext_rst || (overflow && !halted)) && !pin_low_r) begin
         period_sel_r  <= wdrc_pkg::PERIOD_SEL_RST;
         enable_code_r <= wdrc_pkg::EN_CODE_OFF;
      end else if (reg_wr) begin
         case (reg_addr)
            wdrc_pkg::ADDR_PERIOD_SEL: period_sel_r  <= reg_wdata[2:0];
            wdrc_pkg::ADDR_CTRL_ONE:   enable_code_r <= reg_wdata[3:0];
            wdrc_pkg::ADDR_CONFIG:     config_r      <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // Status flags per reset kind and halt
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         expired_r <= 1'b0;
         pdown_r   <= 1'b0;
      end else if (overflow) begin
         expired_r <= 1'b1;
      end else if (halt_cmd) begin
         pdown_r   <= 1'b1;
         expired_r <= 1'b0;
      end else if (sw_clear) begin
         pdown_r   <= 1'b0;
      end
   end

   // Pin level tracker for the falling edge of the reset line
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_low_r <= 1'b1;
      end else begin
         pin_low_r <= ext_rst;
      end
   end

   // Control sequence: start-up delay, run, halt, wake
   always_ff @(posedge clk_sys) begin
      if (rst || ext_rst) begin
         state_r     <= wdrc_pkg::WDRC_ST_DELAY;
         delay_cnt_r <= 32'h0;
      end else begin
         case (state_r)
            wdrc_pkg::WDRC_ST_DELAY: begin
               if (delay_cnt_r >= 32'(STARTUP_CNT - 1)) begin
                  state_r     <= wdrc_pkg::WDRC_ST_RUN;
                  delay_cnt_r <= 32'h0;
               end else begin
                  delay_cnt_r <= delay_cnt_r + 32'h1;
               end
            end
            wdrc_pkg::WDRC_ST_RUN: begin
               if (overflow) begin
                  state_r     <= wdrc_pkg::WDRC_ST_DELAY;
                  delay_cnt_r <= 32'h0;
               end else if (halt_cmd) begin
                  state_r <= wdrc_pkg::WDRC_ST_HALT;
               end
            end
            wdrc_pkg::WDRC_ST_HALT: begin
               if (overflow || wake_req) begin
                  state_r     <= wdrc_pkg::WDRC_ST_WAKE;
                  delay_cnt_r <= 32'h0;
               end
            end
            wdrc_pkg::WDRC_ST_WAKE: begin
               if (delay_cnt_r[10:0] >= ((config_r[wdrc_pkg::CFG_SST_SHORT] && !config_r[wdrc_pkg::CFG_CRYSTAL])
                                          ? wdrc_pkg::SST_SHORT : wdrc_pkg::SST_LONG) - 11'h1) begin
                  state_r     <= wdrc_pkg::WDRC_ST_RUN;
                  delay_cnt_r <= 32'h0;
               end else begin
                  delay_cnt_r <= delay_cnt_r + 32'h1;
               end
            end
            default: begin
               state_r <= wdrc_pkg::WDRC_ST_DELAY;
            end
         endcase
      end
   end

   // Reset and run outputs, all registered
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpu_reset       <= 1'b1;
         cpu_run         <= 1'b0;
         pc_clear        <= 1'b0;
         watchdog_active <= 1'b0;
      end else begin
         cpu_reset       <= ext_rst || (state_r == wdrc_pkg::WDRC_ST_DELAY) ||
                            (overflow && state_r == wdrc_pkg::WDRC_ST_RUN);
         cpu_run         <= (state_r == wdrc_pkg::WDRC_ST_RUN) && !ext_rst && !overflow && !halt_cmd;
         pc_clear        <= overflow && halted;
         watchdog_active <= active;
      end
   end

   // Port registers come up as inputs on power-on
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_data <= wdrc_pkg::PORT_RST;
         port_ctrl <= wdrc_pkg::PORT_RST;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            wdrc_pkg::ADDR_PERIOD_SEL: reg_rdata <= {5'h00, period_sel_r};
            wdrc_pkg::ADDR_CTRL_ONE:   reg_rdata <= {4'h0, enable_code_r};
            wdrc_pkg::ADDR_STATUS:     reg_rdata <= {5'h00, active, pdown_r, expired_r};
            wdrc_pkg::ADDR_CONFIG:     reg_rdata <= config_r;
            default:                   reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

/* verif/wdrc_assertions.sv */
// Concurrent checks on the ports of the watchdog and reset control block
`timescale 1ns/1ps
module wdrc_assertions #(
   parameter int STARTUP_CNT = 20              // Start-up delay in clocks
) (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       external_clear_pin_n,
   input wire logic       supply_drop_restart,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       cpu_reset,
   input wire logic       pc_clear,
   input wire logic       cpu_run,
   input wire logic [7:0] port_data,
   input wire logic [7:0] port_ctrl,
   input wire logic       watchdog_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   int hold_cnt_r;                             // Cycles the device has been held
   // Counts how long the device stays held, so the start-up delay can be measured
   always_ff @(posedge clk_sys) begin
      hold_cnt_r <= cpu_reset ? hold_cnt_r + 1 : 0;
   end
   // Enable code write other than the off pattern while running
   sequence s_code_on;
      cpu_run && reg_wr && reg_addr == wdrc_pkg::ADDR_CTRL_ONE && reg_wdata[3:0] != wdrc_pkg::EN_CODE_OFF;
   endsequence
   // Configuration write that forces the watchdog on while running
   sequence s_force_on;
      cpu_run && reg_wr && reg_addr == wdrc_pkg::ADDR_CONFIG && reg_wdata[wdrc_pkg::CFG_WDT_EN];
   endsequence
   AST_RELEASE: assert property ($fell(rst) |-> cpu_reset && !cpu_run && port_data == 8'hFF && port_ctrl == 8'hFF)
      else $error("state after power-on reset wrong");
   AST_OFF_AT_POWER_UP: assert property ($fell(rst) |-> !watchdog_active)
      else $error("watchdog running after power-up");
   AST_STARTUP: assert property ($fell(cpu_reset) |-> hold_cnt_r >= STARTUP_CNT)
      else $error("start-up delay too short");
   AST_CODE_ON: assert property (s_code_on |-> ##[1:2] watchdog_active)
      else $error("enable code did not start watchdog");
   AST_FORCE_ON: assert property (s_force_on |-> ##[1:2] watchdog_active)
      else $error("configuration did not force watchdog on");
   AST_PERIOD_UPPER: assert property (reg_rd && reg_addr == wdrc_pkg::ADDR_PERIOD_SEL |=> reg_rdata[7:3] == 5'h00)
      else $error("unimplemented period bits not zero");
   AST_PIN: assert property (!external_clear_pin_n |-> ##[1:3] (cpu_reset && !cpu_run))
      else $error("reset pin did not hold the device");
   AST_SUPPLY: assert property (supply_drop_restart |-> ##[1:3] cpu_reset)
      else $error("supply drop did not hold the device");
   AST_WAKE_PULSE: assert property (pc_clear |=> !pc_clear && !cpu_reset)
      else $error("wake clear not a single pulse");
endmodule
bind wdrc_top wdrc_assertions #(.STARTUP_CNT(STARTUP_CNT)) u_wdrc_chk (
   .clk_sys(clk_sys), .rst(rst), .external_clear_pin_n(external_clear_pin_n),
   .supply_drop_restart(supply_drop_restart), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_reset(cpu_reset),
   .pc_clear(pc_clear), .cpu_run(cpu_run), .port_data(port_data), .port_ctrl(port_ctrl),
   .watchdog_active(watchdog_active)
);

/* verif/wdrc_top_test.sv */
// Self-checking testbench for the watchdog and reset control block
`timescale 1ns/1ps
module wdrc_top_test;
   localparam int STARTUP = 20;                 // Shortened start-up delay
   logic        clk_sys, rst, external_clear_pin_n, supply_drop_restart, low_freq_crystal_clock;
   logic        low_speed_internal_osc, halt_req, wake_req, reg_wr, reg_rd;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, port_data, port_ctrl;
   logic        cpu_reset, pc_clear, cpu_run, watchdog_active;
   logic [7:0]  exp_q[$];                       // Expected read data, oldest first
   logic        rd_pend = 1'b0;                 // Read data due this cycle
   logic        pc_seen = 1'b0;                 // Wake clear pulse was seen
   int          err_count = 0, num_checks = 0, waited;
   logic [31:0] seed = 32'h6F2DE975;            // Xorshift state
   wdrc_top #(.STARTUP_CNT(STARTUP)) dut (.clk_sys(clk_sys), .rst(rst), .external_clear_pin_n(external_clear_pin_n),
      .supply_drop_restart(supply_drop_restart), .low_freq_crystal_clock(low_freq_crystal_clock),
      .low_speed_internal_osc(low_speed_internal_osc), .halt_req(halt_req), .wake_req(wake_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cpu_reset(cpu_reset), .pc_clear(pc_clear), .cpu_run(cpu_run), .port_data(port_data),
      .port_ctrl(port_ctrl), .watchdog_active(watchdog_active));
   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk1(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read strobe; the expected value goes to the queue for the monitor
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Watchdog clock ticks on both slow sources, random gaps between them
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         low_freq_crystal_clock <= 1'b1;
         low_speed_internal_osc <= 1'b1;
         @(posedge clk_sys);
         low_freq_crystal_clock <= 1'b0;
         low_speed_internal_osc <= 1'b0;
         repeat (xs() % 3) @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   // Bounded wait: 0 device held, 2 execution allowed
   task automatic wait_for(input int sel, input int bound);
      waited = 0;
      while (waited < bound && !(sel == 0 ? cpu_reset === 1'b1 : cpu_run === 1'b1)) begin
         @(posedge clk_sys);
         #1;
         waited++;
      end
      if (waited >= bound) begin
         err_count++;
         $display("FAIL wait %0d expected 1 seen 0", sel);
         tally_and_finish();
      end
   endtask
   // Monitor: read data is compared in the cycle after the strobe
   always @(posedge clk_sys) begin
      if (rd_pend) begin
         chk8("read data", exp_q.pop_front(), reg_rdata);
      end
      rd_pend <= reg_rd;
      if (pc_clear === 1'b1) begin
         pc_seen <= 1'b1;
      end
   end
   initial begin
      {rst, external_clear_pin_n} = 2'h3;
      {supply_drop_restart, low_freq_crystal_clock, low_speed_internal_osc, halt_req, wake_req} = 5'h00;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
      repeat (20) @(posedge clk_sys);
      #1;
      chk8("port data", 8'hFF, port_data);
      chk8("port ctrl", 8'hFF, port_ctrl);
      chk1("held", 1'b1, cpu_reset);
      @(posedge clk_sys);
      rst <= 1'b0;
      wait_for(2, 100);
      chk1("active", 1'b0, watchdog_active);
      rd(wdrc_pkg::ADDR_PERIOD_SEL, 8'h07);
      rd(wdrc_pkg::ADDR_CTRL_ONE, 8'h0A);
      rd(wdrc_pkg::ADDR_STATUS, 8'h00);
      rd(4'hF, 8'h00);
      // Disabled watchdog never bites; then period codes 0 to 2 on the RC source
      wr(wdrc_pkg::ADDR_CONFIG, 8'h08);
      wr(wdrc_pkg::ADDR_PERIOD_SEL, 8'h00);
      tick(300);
      chk1("bite off", 1'b0, cpu_reset);
      for (int c = 0; c < 3; c++) begin
         wr(wdrc_pkg::ADDR_CTRL_ONE, 8'(xs() % 32'd10));
         wr(wdrc_pkg::ADDR_PERIOD_SEL, c[7:0]);
         wr(wdrc_pkg::ADDR_CLEAR, 8'h01);
         tick(200);
         wr(wdrc_pkg::ADDR_CLEAR, 8'h01);
         tick((256 << c) - 1);
         chk1("early bite", 1'b0, cpu_reset);
         tick(1);
         wait_for(0, 8);
         wait_for(2, 100);
         rd(wdrc_pkg::ADDR_STATUS, 8'h01);
         rd(wdrc_pkg::ADDR_PERIOD_SEL, 8'h07);
      end
      // Supply drop, then reset pin: flags stay as they were
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         supply_drop_restart <= (k == 0);
         external_clear_pin_n <= (k == 0);
         repeat (4) @(posedge clk_sys);
         supply_drop_restart <= 1'b0;
         external_clear_pin_n <= 1'b1;
         wait_for(2, 100);
         rd(wdrc_pkg::ADDR_STATUS, 8'h01);
      end
      // Forced on, dual clear: halves must alternate
      wr(wdrc_pkg::ADDR_CONFIG, 8'h0B);
      wr(wdrc_pkg::ADDR_PERIOD_SEL, 8'h00);
      for (int h = 0; h < 4; h++) begin
         tick(100);
         wr(wdrc_pkg::ADDR_CLEAR, (h == 0) ? 8'h02 : 8'h03);
      end
      tick(55);
      chk1("early bite", 1'b0, cpu_reset);
      tick(1);
      wait_for(0, 8);
      wait_for(2, 100);
      // Power-down, then a watchdog wake
      wr(wdrc_pkg::ADDR_PERIOD_SEL, 8'h00);
      tick(100);
      @(posedge clk_sys);
      halt_req <= 1'b1;
      @(posedge clk_sys);
      halt_req <= 1'b0;
      rd(wdrc_pkg::ADDR_STATUS, 8'h06);
      tick(255);
      chk1("wake early", 1'b0, pc_seen);
      tick(1);
      chk1("wake", 1'b1, pc_seen);
      chk1("no full reset", 1'b0, cpu_reset);
      wait_for(2, 1100);
      chk1("wake delay", 1'b1, waited > 1000);
      rd(wdrc_pkg::ADDR_STATUS, 8'h07);
      rd(wdrc_pkg::ADDR_PERIOD_SEL, 8'h00);
      // Sysclk/4 source must freeze while halted: no bite after more than 256 divided ticks
      wr(wdrc_pkg::ADDR_CONFIG, 8'h05);
      @(posedge clk_sys);
      halt_req <= 1'b1;
      @(posedge clk_sys);
      halt_req <= 1'b0;
      repeat (1200) @(posedge clk_sys);
      rd(wdrc_pkg::ADDR_STATUS, 8'h06);
      tally_and_finish();
   end
endmodule
